//--- afd_cfg.svh
// Constants of the acceleration output data buffer: offsets, fields, resets.
// Assumes inclusion by bare name; holds definitions only.
`ifndef AFD_CFG_SVH
`define AFD_CFG_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define AFD_OFS_INT_ENABLE   8'h2E
`define AFD_OFS_INT_MAP      8'h2F
`define AFD_OFS_INT_SOURCE   8'h30
`define AFD_OFS_DATA_FORMAT  8'h31
`define AFD_OFS_X_LOW        8'h32
`define AFD_OFS_X_HIGH       8'h33
`define AFD_OFS_Y_LOW        8'h34
`define AFD_OFS_Y_HIGH       8'h35
`define AFD_OFS_Z_LOW        8'h36
`define AFD_OFS_Z_HIGH       8'h37
`define AFD_OFS_BUF_CTL      8'h38
`define AFD_OFS_BUF_STATUS   8'h39

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define AFD_CTL_MODE_HI      7
`define AFD_CTL_MODE_LO      6
`define AFD_CTL_TRIG_SEL     5
`define AFD_CTL_COUNT_HI     4
`define AFD_CTL_COUNT_LO     0
`define AFD_STS_TRIG         7
`define AFD_SRC_READY        7
`define AFD_SRC_WMARK        1
`define AFD_SRC_OVERRUN      0
`define AFD_FMT_FULL_RES     3
`define AFD_FMT_JUSTIFY      2
`define AFD_FMT_RANGE_HI     1
`define AFD_FMT_RANGE_LO     0

// ------------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------------
`define AFD_RST_CTL          8'h00
`define AFD_RST_FORMAT       8'h00
`define AFD_RST_INT_ENABLE   8'h00
`define AFD_RST_INT_MAP      8'h00
`define AFD_DEPTH            32
`define AFD_BASE_BITS        10

`endif

//--- afd_pkg.sv
// Types of the acceleration output data buffer.
// Assumes afd_cfg.svh is compiled alongside.
package afd_pkg;

  // ------------------------------------------------------------------
  // Buffer modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    AFD_MODE_BYPASS = 2'h0,
    AFD_MODE_FILL   = 2'h1,
    AFD_MODE_STREAM = 2'h2,
    AFD_MODE_TRIG   = 2'h3
  } afd_mode_e;

  typedef logic [47:0] afd_sample_t;

endpackage : afd_pkg

//--- afd_fifo.sv
// Acceleration output data buffer: result registers, 32-entry store, status.
// Assumes a same-clock measurement core and a same-clock register master.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "afd_cfg.svh"

module afd_fifo
  import afd_pkg::*;
#(
  parameter int DEPTH = `AFD_DEPTH
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        SAMPLE_VALID_I,
  input  wire logic [15:0] SAMPLE_X_I,
  input  wire logic [15:0] SAMPLE_Y_I,
  input  wire logic [15:0] SAMPLE_Z_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  output logic             IRQ_OUT_A_O,
  output logic             IRQ_OUT_B_O
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (DEPTH != 32) begin : g_depth_check
    $error("afd_fifo: DEPTH must be 32 to match the 5-bit count field");
  end

  localparam logic [5:0] DEPTH_C = 6'(DEPTH);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_sync_q1;
  logic rst_sync_q2;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_sync_q1 <= 1'b0;
      rst_sync_q2 <= 1'b0;
    end else begin
      rst_sync_q1 <= 1'b1;
      rst_sync_q2 <= rst_sync_q1;
    end
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  fmt;
    logic [7:0]  ien;
    logic [7:0]  imap;
    logic        ovr;
    logic        trig;
    logic        out_valid;
    afd_sample_t out;
    logic [4:0]  rd;
    logic [4:0]  wr;
    logic [5:0]  cnt;
    logic        burst;
    logic [7:0]  rdata;
    logic        irq_a;
    logic        irq_b;
  } afd_state_s;

  afd_state_s  q;
  afd_state_s  d;
  afd_sample_t mem [DEPTH];
  logic        mem_we;
  logic [4:0]  mem_widx;
  afd_sample_t sample;

  assign sample = {SAMPLE_Z_I, SAMPLE_Y_I, SAMPLE_X_I};

  // ------------------------------------------------------------------
  // Presentation of one axis word
  // ------------------------------------------------------------------
  function automatic logic [15:0] afd_present(input logic [15:0] raw,
                                              input logic [7:0]  fmt);
    logic [3:0] shift;
    shift = 4'(16 - `AFD_BASE_BITS);
    if (fmt[`AFD_FMT_FULL_RES]) begin
      shift = shift - {2'h0, fmt[`AFD_FMT_RANGE_HI:`AFD_FMT_RANGE_LO]};
    end
    if (fmt[`AFD_FMT_JUSTIFY]) begin
      return raw << shift;
    end
    return raw;
  endfunction : afd_present

  // ------------------------------------------------------------------
  // Presented words, one per axis
  // ------------------------------------------------------------------
  logic [15:0] shown [3];

  for (genvar g = 0; g < 3; g++) begin : g_axis
    assign shown[g] = afd_present(q.out[16*g +: 16], q.fmt);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  afd_mode_e   mode;
  logic [5:0]  level;
  logic        data_rd;
  logic        pop;
  logic        trig_evt;
  logic        wmark;
  logic [7:0]  src;
  logic [15:0] word;
  logic [2:0]  axis;

  always_comb begin
    d        = q;
    mem_we   = 1'b0;
    mem_widx = q.wr;
    mode     = afd_mode_e'(q.ctl[`AFD_CTL_MODE_HI:`AFD_CTL_MODE_LO]);
    level    = {1'b0, q.ctl[`AFD_CTL_COUNT_HI:`AFD_CTL_COUNT_LO]};
    data_rd  = RD_I && ADDR_I >= `AFD_OFS_X_LOW
                    && ADDR_I <= `AFD_OFS_Z_HIGH;
    pop      = q.burst && !data_rd;
    d.burst  = data_rd;
    trig_evt = q.ctl[`AFD_CTL_TRIG_SEL] ? q.irq_b : q.irq_a;
    wmark    = 1'b0;
    src      = 8'h00;
    word     = 16'h0000;
    axis     = 3'h0;

    // Register writes
    if (WR_I) begin
      case (ADDR_I)
        `AFD_OFS_INT_ENABLE: begin
          d.ien = WDATA_I;
        end
        `AFD_OFS_INT_MAP: begin
          d.imap = WDATA_I;
        end
        `AFD_OFS_DATA_FORMAT: begin
          d.fmt = WDATA_I;
        end
        `AFD_OFS_BUF_CTL: begin
          d.ctl  = WDATA_I;
          d.trig = 1'b0;
          if (WDATA_I[`AFD_CTL_MODE_HI:`AFD_CTL_MODE_LO] == AFD_MODE_BYPASS) begin
            d.cnt = 6'h00;
            d.rd  = q.wr;
          end
        end
        default: begin
        end
      endcase
    end

    // Pop one level after a result burst
    if (pop) begin
      d.ovr = 1'b0;
      if (d.cnt != 6'h00) begin
        d.out = mem[d.rd];
        d.rd  = d.rd + 5'h01;
        d.cnt = d.cnt - 6'h01;
      end else begin
        d.out_valid = 1'b0;
      end
    end

    // First trigger only
    if (mode == AFD_MODE_TRIG && trig_evt && !q.trig) begin
      d.trig = 1'b1;
    end

    // Sample intake
    if (SAMPLE_VALID_I) begin
      if (!d.out_valid) begin
        d.out       = sample;
        d.out_valid = 1'b1;
      end else begin
        case (mode)
          AFD_MODE_BYPASS: begin
            d.out = sample;
            d.ovr = 1'b1;
          end
          AFD_MODE_FILL: begin
            if (d.cnt == DEPTH_C) begin
              d.ovr = 1'b1;
            end else begin
              mem_we = 1'b1;
            end
          end
          AFD_MODE_STREAM: begin
            if (d.cnt == DEPTH_C) begin
              d.rd  = d.rd + 5'h01;
              d.cnt = d.cnt - 6'h01;
              d.ovr = 1'b1;
            end
            mem_we = 1'b1;
          end
          AFD_MODE_TRIG: begin
            if (!d.trig) begin
              if (d.cnt != 6'h00 && d.cnt >= level) begin
                d.rd  = d.rd + 5'h01;
                d.cnt = d.cnt - 6'h01;
              end
              mem_we = 1'b1;
            end else if (d.cnt == DEPTH_C) begin
              d.ovr = 1'b1;
            end else begin
              mem_we = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (mem_we) begin
      mem_widx = d.wr;
      d.wr     = d.wr + 5'h01;
      d.cnt    = d.cnt + 6'h01;
    end

    // Interrupt sources
    if (level == 6'h00) begin
      wmark = 1'b1;
    end else if (mode == AFD_MODE_FILL || mode == AFD_MODE_STREAM) begin
      wmark = d.cnt >= level;
    end
    src[`AFD_SRC_READY]   = d.out_valid;
    src[`AFD_SRC_WMARK]   = wmark;
    src[`AFD_SRC_OVERRUN] = d.ovr;
    d.irq_a = |(src & d.ien & ~d.imap);
    d.irq_b = |(src & d.ien & d.imap);

    // Read data, stands one cycle
    d.rdata = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        `AFD_OFS_INT_ENABLE: begin
          d.rdata = q.ien;
        end
        `AFD_OFS_INT_MAP: begin
          d.rdata = q.imap;
        end
        `AFD_OFS_INT_SOURCE: begin
          d.rdata = {q.out_valid, 5'h00,
                     (level == 6'h00) ||
                     ((mode == AFD_MODE_FILL || mode == AFD_MODE_STREAM)
                      && q.cnt >= level),
                     q.ovr};
        end
        `AFD_OFS_DATA_FORMAT: begin
          d.rdata = q.fmt;
        end
        `AFD_OFS_BUF_CTL: begin
          d.rdata = q.ctl;
        end
        `AFD_OFS_BUF_STATUS: begin
          d.rdata = {q.trig, 1'b0, q.cnt};
        end
        default: begin
          if (data_rd) begin
            axis = 3'(ADDR_I - `AFD_OFS_X_LOW);
            case (axis[2:1])
              2'h0:    word = shown[0];
              2'h1:    word = shown[1];
              default: word = shown[2];
            endcase
            d.rdata = axis[0] ? word[15:8] : word[7:0];
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge rst_sync_q2) begin
    if (!rst_sync_q2) begin
      q      <= '0;
      q.ctl  <= `AFD_RST_CTL;
      q.fmt  <= `AFD_RST_FORMAT;
      q.ien  <= `AFD_RST_INT_ENABLE;
      q.imap <= `AFD_RST_INT_MAP;
    end else begin
      q <= d;
    end
  end

  // Sample store, no reset needed
  always_ff @(posedge CLK_I) begin
    if (mem_we) begin
      mem[mem_widx] <= sample;
    end
  end

  assign RDATA_O     = q.rdata;
  assign IRQ_OUT_A_O = q.irq_a;
  assign IRQ_OUT_B_O = q.irq_b;

endmodule : afd_fifo

//--- afd_fifo_assertions.sv
// Port checker of the output data buffer.
// Assumes binding to afd_fifo; sees only its ports.
`timescale 1ns/1ps
module afd_fifo_assertions #(
  parameter int DEPTH = 32
) (
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  input wire logic        SAMPLE_VALID_I,
  input wire logic [15:0] SAMPLE_X_I,
  input wire logic [15:0] SAMPLE_Y_I,
  input wire logic [15:0] SAMPLE_Z_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [7:0]  WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [7:0]  RDATA_O,
  input wire logic        IRQ_OUT_A_O,
  input wire logic        IRQ_OUT_B_O
);
  // ------------------------------------------------------------------
  // Shadow of control, enable and map registers
  // ------------------------------------------------------------------
  logic [7:0] ctl_q;
  logic [7:0] en_q;
  logic [7:0] map_q;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctl_q <= 8'h00;
      en_q  <= 8'h00;
      map_q <= 8'h00;
    end else if (WR_I) begin
      if (ADDR_I == 8'h38) ctl_q <= WDATA_I;
      if (ADDR_I == 8'h2E) en_q <= WDATA_I;
      if (ADDR_I == 8'h2F) map_q <= WDATA_I;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_rdata_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_unmapped_reads_zero: assert property (
    RD_I && (ADDR_I < 8'h2E || ADDR_I > 8'h39) |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_status_count_range: assert property (
    RD_I && ADDR_I == 8'h39 |=> !RDATA_O[6] && RDATA_O[5:0] <= 6'(DEPTH))
    else $error("status count out of range");
  a_bypass_store_empty: assert property (
    RD_I && ADDR_I == 8'h39 && ctl_q[7:6] == 2'b00 |=> RDATA_O[5:0] == 6'h00)
    else $error("store not empty in bypass");
  a_zero_count_wmark: assert property (
    RD_I && ADDR_I == 8'h30 && ctl_q[4:0] == 5'h00 |=> RDATA_O[1])
    else $error("watermark low with zero count");
  a_ctl_read_back: assert property (
    RD_I && ADDR_I == 8'h38 |=> RDATA_O == $past(ctl_q))
    else $error("control read back wrong");
  a_irq_quiet_off: assert property (
    en_q == 8'h00 && $past(en_q) == 8'h00 && $past(en_q, 2) == 8'h00
    |-> !IRQ_OUT_A_O && !IRQ_OUT_B_O)
    else $error("irq high with all sources disabled");
  a_ready_irq_a: assert property (
    en_q[7] && !map_q[7] && SAMPLE_VALID_I |-> ##[1:2] IRQ_OUT_A_O)
    else $error("ready not on irq a");

  c_result_burst: cover property (RD_I && ADDR_I == 8'h37);
  c_irq_a_high: cover property (IRQ_OUT_A_O);
  c_trig_sample: cover property (SAMPLE_VALID_I && ctl_q[7:6] == 2'b11);
endmodule : afd_fifo_assertions

bind afd_fifo afd_fifo_assertions #(.DEPTH(DEPTH)) u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_X_I(SAMPLE_X_I), .SAMPLE_Y_I(SAMPLE_Y_I),
  .SAMPLE_Z_I(SAMPLE_Z_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .IRQ_OUT_A_O(IRQ_OUT_A_O), .IRQ_OUT_B_O(IRQ_OUT_B_O));

//--- afd_core_model.sv
// Measurement core model: one-cycle sample pulses on request.
// Assumes the buffer's clock; drives the sample ports only.
`timescale 1ns/1ps
module afd_core_model
  import afd_pkg::*;
(
  input  wire logic  clk_i,
  output logic       valid_o,
  output logic [15:0] x_o,
  output logic [15:0] y_o,
  output logic [15:0] z_o
);
  initial begin
    valid_o = 1'b0;
    {z_o, y_o, x_o} = '0;
  end

  task automatic send(afd_sample_t s);
    @(posedge clk_i);
    valid_o <= 1'b1;
    {z_o, y_o, x_o} <= s;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Idle lines show the inverse, never a held value
    {z_o, y_o, x_o} <= ~s;
  endtask : send
endmodule : afd_core_model

//--- afd_fifo_tb.sv
// Testbench of the output data buffer: register access and buffer modes.
// Assumes afd_fifo, its checker and the core model are compiled first.
`timescale 1ns/1ps
module afd_fifo_tb
  import afd_pkg::*;
;
  logic CLK_I, RST_B_I, WR_I, RD_I;
  logic [7:0] ADDR_I, WDATA_I;
  wire logic [7:0] RDATA_O;
  wire logic IRQ_OUT_A_O, IRQ_OUT_B_O, vld;
  wire logic [15:0] sx, sy, sz;
  int n_mismatch = 0;
  int n_compared = 0;

  afd_core_model core (.clk_i(CLK_I), .valid_o(vld), .x_o(sx), .y_o(sy), .z_o(sz));
  afd_fifo #(.DEPTH(32)) DUT (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .SAMPLE_VALID_I(vld),
    .SAMPLE_X_I(sx), .SAMPLE_Y_I(sy), .SAMPLE_Z_I(sz), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_OUT_A_O(IRQ_OUT_A_O),
    .IRQ_OUT_B_O(IRQ_OUT_B_O));

  // ------------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge CLK_I);
    WR_I <= 1'b1;
    ADDR_I <= a;
    WDATA_I <= d;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge CLK_I);
    RD_I <= 1'b1;
    ADDR_I <= a;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1 chk($sformatf("reg %h", a), RDATA_O, e);
  endtask : rd

  // Six result bytes back to back, one pop afterwards
  task automatic burst(afd_sample_t e, bit on);
    for (int i = 0; i <= 6; i++) begin
      @(posedge CLK_I);
      RD_I <= (i < 6);
      ADDR_I <= 8'h32 + 8'(i);
      if (i > 0 && on) #1 chk("result byte", RDATA_O, e[8*(i-1) +: 8]);
    end
  endtask : burst

  function automatic afd_sample_t smp(int k);
    smp = {16'(16'h0100 + k), 16'(-k), 16'(k)};
  endfunction : smp

  task automatic feed(int base, int n);
    for (int k = 0; k < n; k++) core.send(smp(base + k));
  endtask : feed

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------------
  // Clock, watchdog, tests
  // ------------------------------------------------------------------
  initial begin
    CLK_I = 1'b0;
    forever #2 CLK_I = ~CLK_I;
  end

  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  initial begin
    RST_B_I = 1'b0;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 8'h00;
    WDATA_I = 8'h00;
    repeat (10) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    rd(8'h38, 8'h00);
    rd(8'h39, 8'h00);
    rd(8'h30, 8'h02);
    wr(8'h39, 8'h55);
    rd(8'h39, 8'h00);
    rd(8'h3A, 8'h00);
    feed(300, 1);
    rd(8'h30, 8'h82);
    feed(301, 1);
    rd(8'h30, 8'h83);
    burst(smp(301), 1'b1);
    rd(8'h30, 8'h02);
    wr(8'h31, 8'h04);
    core.send(48'h0000_FFFF_0005);
    burst(48'h0000_FFC0_0140, 1'b1);
    wr(8'h31, 8'h0D);
    rd(8'h31, 8'h0D);
    core.send(48'h0001_FFFF_0005);
    burst(48'h0020_FFE0_00A0, 1'b1);
    wr(8'h31, 8'h00);
    wr(8'h38, 8'h44);
    feed(0, 34);
    rd(8'h39, 8'h20);
    rd(8'h30, 8'h83);
    burst(smp(0), 1'b1);
    rd(8'h39, 8'h1F);
    feed(34, 1);
    rd(8'h39, 8'h20);
    wr(8'h38, 8'h00);
    rd(8'h39, 8'h00);
    wr(8'h38, 8'h9F);
    feed(100, 40);
    rd(8'h39, 8'h20);
    for (int k = 0; k < 33; k++) burst(smp(139), k == 32);
    rd(8'h39, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h38, 8'h00);
    wr(8'h2E, 8'h80);
    wr(8'h38, 8'hE2);
    feed(200, 5);
    rd(8'h39, 8'h02);
    chk("irq a", {7'h00, IRQ_OUT_A_O}, 8'h01);
    wr(8'h38, 8'hC2);
    feed(210, 40);
    rd(8'h39, 8'hA0);
    rd(8'h38, 8'hC2);
    chk("irq b", {7'h00, IRQ_OUT_B_O}, 8'h00);
    wr(8'h2F, 8'h80);
    rd(8'h2E, 8'h80);
    rd(8'h2F, 8'h80);
    chk("irq b mapped", {7'h00, IRQ_OUT_B_O}, 8'h01);
    chk("irq a unmapped", {7'h00, IRQ_OUT_A_O}, 8'h00);
    summarize();
  end
endmodule : afd_fifo_tb
